//--- odi_operand_decode_interlock.sv
// operand field decode, flag update and pipeline interlock for the cpu core
`timescale 1ns/100ps

module odi_operand_decode_interlock
  import odi_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  // instruction issue
  input  wire logic        insnValid,
  output logic             insnReady,
  input  wire logic [15:0] insnWord,
  input  odi_class_t       insnClass,
  input  odi_imm_t         insnImmKind,
  input  odi_amode_t       insnAddrMode,
  input  wire logic        insnFormatA,
  input  wire logic        insnReadsDest,
  input  wire logic        insnReadsSource,
  input  wire logic        insnWritesDest,
  input  wire logic        insnUsesDedicated,
  input  wire logic        insnUsesMem,
  input  wire logic [7:0]  insnFlagOps,
  input  wire logic [3:0]  aluFlags,
  // memory access
  input  wire logic        memReadyPin,
  output logic             memReq,
  output logic             memDone,
  // decoded operands
  output logic             issuePulse,
  output logic [31:0]      operandValue,
  output logic [3:0]       destRegIdx,
  output logic [3:0]       sourceRegIdx,
  output logic [2:0]       dedicatedIdx,
  output logic [3:0]       coprocDestIdx,
  output logic [3:0]       coprocSourceIdx,
  output logic [3:0]       flagsOut,
  // address register stepping
  output logic [3:0]       addrRegIdx,
  output logic [31:0]      addrOffset,
  output logic             regStepEn,
  output logic [3:0]       regStepIdx,
  output logic [31:0]      regStepVal
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic odiFlag(input logic [1:0] op,
                                   input logic       res,
                                   input logic       cur);
    logic v;
    v = cur;
    case (op)
      FL_CHANGE: v = res;
      FL_KEEP:   v = cur;
      FL_CLEAR:  v = 1'b0;
      default:   v = 1'b1;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] odiExtend(input odi_imm_t   kind,
                                            input logic [15:0] w);
    logic [31:0] v;
    v = 32'h00000000;
    case (kind)
      IMM_S5:      v = {{27{w[8]}}, w[8:4]};
      IMM_U4:      v = {28'h0000000, w[7:4]};
      IMM_U5:      v = {27'h0000000, w[8:4]};
      IMM_S10:     v = {{22{w[7]}}, w[7:0], 2'h0};
      IMM_U10:     v = {22'h000000, w[7:0], 2'h0};
      IMM_U8:      v = {24'h000000, w[7:0]};
      IMM_DIR8:    v = {24'h000000, w[7:0]};
      IMM_DIR9:    v = {23'h000000, w[7:0], 1'h0};
      IMM_DIR10:   v = {22'h000000, w[7:0], 2'h0};
      IMM_LABEL9:  v = {{23{w[7]}}, w[7:0], 1'h0};
      IMM_LABEL12: v = {{20{w[10]}}, w[10:0], 1'h0};
      IMM_DISP10:  v = {{22{w[11]}}, w[11:4], 2'h0};
      IMM_DISP9:   v = {{23{w[11]}}, w[11:4], 1'h0};
      IMM_DISP8:   v = {{24{w[11]}}, w[11:4]};
      IMM_UDISP6:  v = {26'h0000000, w[7:4], 2'h0};
      default:     v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic odiIsStackPtr(input logic [2:0] d);
    return (d == DED_SUPERVISOR_STACK_PTR) || (d == DED_USER_STACK_PTR);
  endfunction

  function automatic logic odiIsMulReg(input logic [2:0] d);
    return (d == DED_MULTIPLY_RESULT_HIGH) || (d == DED_MULTIPLY_RESULT_LOW);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  odi_state_t  state_q, state_d;
  logic [31:0] ctrl_q;
  logic [15:0] stallCnt_q;
  logic [3:0]  flags_q;
  logic        ack_q;
  logic        rdySync1_q, rdySync2_q;
  logic        prevLoad_q, prevStack_q, prevMul_q;
  logic [3:0]  prevDest_q;
  logic        issue_q;
  logic [31:0] operand_q;
  logic [3:0]  destIdx_q, srcIdx_q, copD_q, copS_q, addrIdx_q;
  logic [2:0]  dedIdx_q;
  logic [31:0] addrOff_q;
  logic        memReq_q, memDone_q;
  logic        stepPend_q, stepEn_q;
  logic [3:0]  stepIdx_q;
  logic [31:0] stepVal_q;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  // general and coprocessor fields share the nibble layout
  wire logic [3:0] fieldDest = insnWord[3:0];
  wire logic [3:0] fieldSrc  = insnWord[7:4];
  wire logic [2:0] fieldDed  = insnWord[6:4];
  wire logic [31:0] extValue = odiExtend(insnImmKind, insnWord);

  // assembler-only forms arrive already substituted; no opcode here
  wire logic readsPrevDest =
    (insnReadsDest   && (fieldDest == prevDest_q)) ||
    (insnReadsSource && (fieldSrc  == prevDest_q));

  wire logic touchesStack =
    ((insnReadsDest || insnWritesDest) && (fieldDest == STACK_REG_FIFTEEN)) ||
    (insnReadsSource && (fieldSrc == STACK_REG_FIFTEEN)) ||
    (insnUsesDedicated && odiIsStackPtr(fieldDed)) ||
    (insnAddrMode == AM_PUSH) || (insnAddrMode == AM_POP);

  wire logic touchesMul = insnUsesDedicated && odiIsMulReg(fieldDed);

  // ---------------------------------------------------------------
  // interlock
  // ---------------------------------------------------------------
  wire logic ilkEnable = ctrl_q[CTRL_ILK_BIT];
  wire logic hazLoad   = prevLoad_q && readsPrevDest;
  wire logic hazStack  = prevStack_q &&
                         (touchesStack || insnFormatA);
  wire logic hazMul    = prevMul_q && touchesMul;
  wire logic hazard    = ilkEnable && insnValid &&
                         (hazLoad || hazStack || hazMul);
  wire logic running   = (state_q == ST_RUN);
  // one cycle issue when no hazard and no access pending
  wire logic issue     = insnValid && running && !hazard;
  wire logic stallCyc  = running && hazard;
  wire logic accessEnd = (state_q == ST_MEM) && rdySync2_q;

  assign insnReady = running && !hazard;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (issue && insnUsesMem) begin
          state_d = ST_MEM;
        end
      end
      ST_MEM: begin
        if (rdySync2_q) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  wire logic [3:0] flagsNext = {
    odiFlag(insnFlagOps[7:6], aluFlags[FLAG_NEG],   flags_q[FLAG_NEG]),
    odiFlag(insnFlagOps[5:4], aluFlags[FLAG_ZERO],  flags_q[FLAG_ZERO]),
    odiFlag(insnFlagOps[3:2], aluFlags[FLAG_OVF],   flags_q[FLAG_OVF]),
    odiFlag(insnFlagOps[1:0], aluFlags[FLAG_CARRY], flags_q[FLAG_CARRY])
  };

  // ---------------------------------------------------------------
  // address stepping
  // ---------------------------------------------------------------
  wire logic        amStep  = (insnAddrMode != AM_NONE);
  wire logic [3:0]  amIdx   = (insnAddrMode == AM_POSTINC) ?
                              fieldDest : STACK_REG_FIFTEEN;
  wire logic [31:0] amStepV = (insnAddrMode == AM_PUSH) ?
                              STEP_WORD_NEG : STEP_WORD;
  wire logic [31:0] amOff   = (insnAddrMode == AM_PUSH) ?
                              STEP_WORD_NEG : 32'h00000000;
  // step lands after the access, or right away when none is made
  wire logic stepNow  = (issue && amStep && !insnUsesMem) ||
                        (accessEnd && stepPend_q);

  // ---------------------------------------------------------------
  // sequential core
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    // ready comes from a pin: two flops before use
    rdySync1_q <= memReadyPin;
    rdySync2_q <= rdySync1_q;
    if (rst) begin
      state_q     <= ST_RUN;
      prevLoad_q  <= 1'b0;
      prevStack_q <= 1'b0;
      prevMul_q   <= 1'b0;
      prevDest_q  <= 4'h0;
      issue_q     <= 1'b0;
      memReq_q    <= 1'b0;
      memDone_q   <= 1'b0;
      flags_q     <= FLAGS_RESET;
      stallCnt_q  <= STALL_CNT_RESET;
      stepPend_q  <= 1'b0;
      stepEn_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      issue_q   <= issue;
      memDone_q <= accessEnd;
      stepEn_q  <= stepNow;
      if (issue && insnUsesMem) begin
        memReq_q <= 1'b1;
      end else if (accessEnd) begin
        memReq_q <= 1'b0;
      end
      if (issue) begin
        prevLoad_q  <= (insnClass == CL_LOAD);
        prevStack_q <= (insnClass == CL_STACKGRP);
        prevMul_q   <= (insnClass == CL_MUL);
        prevDest_q  <= fieldDest;
        flags_q     <= flagsNext;
      end else if (running) begin
        // a bubble or a stall cycle separates the pair
        prevLoad_q  <= 1'b0;
        prevStack_q <= 1'b0;
        prevMul_q   <= 1'b0;
      end
      if (stallCyc && (stallCnt_q != 16'hffff)) begin
        stallCnt_q <= stallCnt_q + 16'h0001;
      end
      if (issue && amStep && insnUsesMem) begin
        stepPend_q <= 1'b1;
      end else if (accessEnd) begin
        stepPend_q <= 1'b0;
      end
    end
  end

  // data captured only at issue, so a stall has no effect on them
  always_ff @(posedge mclk) begin
    if (rst) begin
      operand_q <= 32'h00000000;
      destIdx_q <= 4'h0;
      srcIdx_q  <= 4'h0;
      dedIdx_q  <= 3'h0;
      copD_q    <= 4'h0;
      copS_q    <= 4'h0;
      addrIdx_q <= 4'h0;
      addrOff_q <= 32'h00000000;
      stepIdx_q <= 4'h0;
      stepVal_q <= 32'h00000000;
    end else if (issue) begin
      operand_q <= extValue;
      destIdx_q <= fieldDest;
      srcIdx_q  <= fieldSrc;
      dedIdx_q  <= fieldDed;
      copD_q    <= insnWord[3:0];
      copS_q    <= insnWord[7:4];
      addrIdx_q <= amIdx;
      addrOff_q <= amOff;
      stepIdx_q <= amIdx;
      stepVal_q <= amStepV;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  wire logic wbReq   = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic hitCtrl = (wb_adr_i == REG_CTRL);
  wire logic hitStat = (wb_adr_i == REG_STATUS);
  wire logic hitFlag = (wb_adr_i == REG_FLAGS);
  wire logic hitOper = (wb_adr_i == REG_OPERAND);
  wire logic hitIdx  = (wb_adr_i == REG_INDEX);
  wire logic [31:0] statusWord = {13'h0000, stepPend_q, memReq_q,
                                  state_q == ST_MEM, stallCnt_q};
  wire logic [31:0] indexWord  = {13'h0000, dedIdx_q, copS_q, copD_q,
                                  srcIdx_q, destIdx_q};
  wire logic [31:0] readMux =
    hitCtrl ? ctrl_q :
    hitStat ? statusWord :
    hitFlag ? {28'h0000000, flags_q} :
    hitOper ? operand_q :
    hitIdx  ? indexWord : 32'h00000000;
  logic [31:0] rdata_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      ctrl_q  <= CTRL_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= wbReq;
      if (wbReq) begin
        rdata_q <= readMux;
      end
      if (wbReq && wb_we_i && hitCtrl && wb_sel_i[0]) begin
        ctrl_q <= {31'h00000000, wb_dat_i[CTRL_ILK_BIT]};
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = rdata_q;
  assign memReq          = memReq_q;
  assign memDone         = memDone_q;
  assign issuePulse      = issue_q;
  assign operandValue    = operand_q;
  assign destRegIdx      = destIdx_q;
  assign sourceRegIdx    = srcIdx_q;
  assign dedicatedIdx    = dedIdx_q;
  assign coprocDestIdx   = copD_q;
  assign coprocSourceIdx = copS_q;
  assign flagsOut        = flags_q;
  assign addrRegIdx      = addrIdx_q;
  assign addrOffset      = addrOff_q;
  assign regStepEn       = stepEn_q;
  assign regStepIdx      = stepIdx_q;
  assign regStepVal      = stepVal_q;

endmodule

//--- odi_pkg.sv
// shared constants and types of the operand decode and interlock block
package odi_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_FLAGS    = 8'h08;
  localparam logic [7:0]  REG_OPERAND  = 8'h0c;
  localparam logic [7:0]  REG_INDEX    = 8'h10;
  localparam logic [31:0] CTRL_RESET   = 32'h00000001;
  localparam int unsigned CTRL_ILK_BIT = 0;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;

  // ---------------------------------------------------------------
  // flag positions inside the four-bit flag vector
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_NEG  = 3;
  localparam int unsigned FLAG_ZERO = 2;
  localparam int unsigned FLAG_OVF  = 1;
  localparam int unsigned FLAG_CARRY = 0;

  // ---------------------------------------------------------------
  // general and dedicated register numbers
  // ---------------------------------------------------------------
  localparam logic [3:0] R13_ALIAS_IDX      = 4'hd;
  localparam logic [3:0] FRAME_POINTER_IDX  = 4'he;
  localparam logic [3:0] STACK_REG_FIFTEEN  = 4'hf;
  localparam logic [2:0] DED_VECTOR_TABLE_BASE    = 3'h0;
  localparam logic [2:0] DED_RETURN_POINTER       = 3'h1;
  localparam logic [2:0] DED_SUPERVISOR_STACK_PTR = 3'h2;
  localparam logic [2:0] DED_USER_STACK_PTR       = 3'h3;
  localparam logic [2:0] DED_MULTIPLY_RESULT_HIGH = 3'h4;
  localparam logic [2:0] DED_MULTIPLY_RESULT_LOW  = 3'h5;

  // ---------------------------------------------------------------
  // address stepping and stall counter reset
  // ---------------------------------------------------------------
  localparam logic [31:0] STEP_WORD     = 32'h00000004;
  localparam logic [31:0] STEP_WORD_NEG = 32'hfffffffc;
  localparam logic [15:0] STALL_CNT_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IMM_NONE, IMM_S5, IMM_U4, IMM_U5, IMM_S10, IMM_U10, IMM_U8,
    IMM_DIR8, IMM_DIR9, IMM_DIR10, IMM_LABEL9, IMM_LABEL12,
    IMM_DISP10, IMM_DISP9, IMM_DISP8, IMM_UDISP6
  } odi_imm_t;

  typedef enum logic [1:0] {
    AM_NONE, AM_POSTINC, AM_PUSH, AM_POP
  } odi_amode_t;

  typedef enum logic [1:0] {
    CL_PLAIN, CL_LOAD, CL_STACKGRP, CL_MUL
  } odi_class_t;

  typedef enum logic [1:0] {
    FL_CHANGE, FL_KEEP, FL_CLEAR, FL_SET
  } odi_flagop_t;

  typedef enum logic {
    ST_RUN, ST_MEM
  } odi_state_t;

endpackage

//--- odi_properties.sv
// assertion checker for the operand decode and interlock block
`timescale 1ns/100ps
module odi_interlock_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        insnValid,
  input wire logic        insnReady,
  input wire logic [15:0] insnWord,
  input wire logic        insnUsesMem,
  input wire logic [7:0]  insnFlagOps,
  input wire logic [3:0]  aluFlags,
  input wire logic        memReadyPin,
  input wire logic        memReq,
  input wire logic        memDone,
  input wire logic        issuePulse,
  input wire logic [3:0]  destRegIdx,
  input wire logic [3:0]  sourceRegIdx,
  input wire logic [3:0]  flagsOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence issueS;
    insnValid && insnReady;
  endsequence
  sequence heldS;
    insnValid && !insnReady && !memReq ##1 insnValid;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  issue_pulse_a: assert property (issueS |=> issuePulse)
    else $error("issue pulse missing");
  stall_quiet_a: assert property (
    !(insnValid && insnReady) |=> !issuePulse)
    else $error("issue pulse without issue");
  field_split_a: assert property (issueS |=>
    destRegIdx == $past(insnWord[3:0]) &&
    sourceRegIdx == $past(insnWord[7:4]))
    else $error("register field wrong");
  stall_once_a: assert property (heldS |-> insnReady)
    else $error("stall longer than one cycle");
  mem_start_a: assert property (issueS ##0 insnUsesMem |=> memReq)
    else $error("memory access not started");
  mem_hold_a: assert property (
    memReq && !memReadyPin |=> memReq [*2])
    else $error("access ended without ready");
  mem_end_a: assert property (memDone |-> !memReq && $past(memReq))
    else $error("done without access");
  flag_set_a: assert property (
    issueS ##0 insnFlagOps[7:6] == 2'h3 |=> flagsOut[3])
    else $error("negative flag not set");
  flag_clear_a: assert property (
    issueS ##0 insnFlagOps[5:4] == 2'h2 |=> !flagsOut[2])
    else $error("zero flag not cleared");
  flag_keep_a: assert property (
    issueS ##0 insnFlagOps[3:2] == 2'h1 |=> $stable(flagsOut[1]))
    else $error("overflow flag not kept");
  flag_calc_a: assert property (issueS ##0 insnFlagOps[1:0] == 2'h0
    |=> flagsOut[0] == $past(aluFlags[0]))
    else $error("carry not taken");
endmodule
bind odi_operand_decode_interlock odi_interlock_props i_odi_interlock_props (
  .mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .insnValid, .insnReady,
  .insnWord, .insnUsesMem, .insnFlagOps, .aluFlags, .memReadyPin, .memReq,
  .memDone, .issuePulse, .destRegIdx, .sourceRegIdx, .flagsOut);

//--- odi_mem_model.sv
// data bus partner that answers memory accesses after a chosen wait
`timescale 1ns/100ps
module odi_mem_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       memReq,
  input  wire logic [3:0] waitCycles,
  output logic            memReadyPin
);
  logic [3:0] waitCnt_q;
  // ready stays up until the core drops its request
  always @(posedge mclk) begin
    if (rst || !memReq) begin
      waitCnt_q <= 4'h0;
      memReadyPin <= 1'b0;
    end else if (waitCnt_q >= waitCycles) begin
      memReadyPin <= 1'b1;
    end else begin
      waitCnt_q <= waitCnt_q + 4'h1;
    end
  end
endmodule

//--- odi_operand_decode_interlock_test.sv
// self-checking testbench for the operand decode and interlock block
`timescale 1ns/100ps
module odi_operand_decode_interlock_test
  import odi_pkg::*;
;
  logic        mclk, rst, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic        insnValid, insnReady, insnFormatA, insnReadsDest;
  logic        insnReadsSource, insnWritesDest, insnUsesDedicated;
  logic        insnUsesMem, memReadyPin, memReq, memDone, issuePulse;
  logic        regStepEn;
  logic [2:0]  dedicatedIdx;
  logic [3:0]  wb_sel_i, aluFlags, destRegIdx, sourceRegIdx, flagsOut;
  logic [3:0]  coprocDestIdx, coprocSourceIdx, addrRegIdx, regStepIdx;
  logic [3:0]  memWait;
  logic [7:0]  wb_adr_i, insnFlagOps;
  logic [15:0] insnWord;
  logic [31:0] wb_dat_i, wb_dat_o, operandValue, addrOffset, regStepVal;
  odi_class_t  insnClass;
  odi_imm_t    insnImmKind;
  odi_amode_t  insnAddrMode;
  int          miscompares, n_tests;

  odi_operand_decode_interlock i_odi_operand_decode_interlock (.*);
  odi_mem_model i_odi_mem_model (.mclk(mclk), .rst(rst), .memReq(memReq),
    .waitCycles(memWait), .memReadyPin(memReadyPin));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge mclk);
  endtask
  // q holds {format A, reads dest, reads source, writes dest, dedicated, mem}
  task automatic issue(input odi_class_t c, input logic [15:0] w,
                       input logic [5:0] q, input odi_imm_t k, output int n);
    insnClass <= c;
    insnWord <= w;
    insnImmKind <= k;
    {insnFormatA, insnReadsDest, insnReadsSource} <= q[5:3];
    {insnWritesDest, insnUsesDedicated, insnUsesMem} <= q[2:0];
    insnValid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (insnReady !== 1'b1);
  endtask
  // a bubble also clears the remembered previous instruction
  task automatic idle(input int k);
    insnValid <= 1'b0;
    repeat (k) @(posedge mclk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, REG_CTRL, 32'h0, q);
    check(q, CTRL_RESET);
    wb(1'b1, REG_FLAGS, 32'hf, q);
    wb(1'b0, REG_FLAGS, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    $display("register test done");
  endtask
  task automatic t_decode;
    odi_imm_t k[15] = '{IMM_S5, IMM_U5, IMM_U4, IMM_S10, IMM_U10, IMM_DIR8,
      IMM_DIR9, IMM_DIR10, IMM_LABEL9, IMM_LABEL12, IMM_DISP10, IMM_DISP9,
      IMM_DISP8, IMM_UDISP6, IMM_U8};
    logic [15:0] w[15] = '{16'h0100, 16'h01f0, 16'h00f0, 16'h0080, 16'h00ff,
      16'h00ff, 16'h00ff, 16'h00ff, 16'h0080, 16'h0400, 16'h0800, 16'h07f0,
      16'h0800, 16'h00f0, 16'h00ff};
    logic [31:0] e[15] = '{32'hfffffff0, 32'h1f, 32'hf, 32'hfffffe00, 32'h3fc,
      32'hff, 32'h1fe, 32'h3fc, 32'hffffff00, 32'hfffff800, 32'hfffffe00,
      32'hfe, 32'hffffff80, 32'h3c, 32'hff};
    int n;
    for (int i = 0; i < 15; i++) begin
      issue(CL_PLAIN, w[i], 6'h0, k[i], n);
      idle(1);
      check(operandValue, e[i]);
    end
    for (int i = 0; i < 6; i++) begin
      issue(CL_PLAIN, 16'(i << 4), 6'h02, IMM_NONE, n);
      idle(1);
      check(32'(dedicatedIdx), 32'(i));
    end
    issue(CL_PLAIN, 16'h00a5, 6'h0, IMM_NONE, n);
    idle(1);
    check(32'({coprocSourceIdx, coprocDestIdx}), 32'ha5);
    $display("decode test done");
  endtask
  task automatic pair(input odi_class_t c, input logic [15:0] w,
                      input logic [5:0] q, input int e);
    int n;
    issue(c, 16'h0005, 6'h04, IMM_NONE, n);
    issue(CL_PLAIN, w, q, IMM_NONE, n);
    idle(2);
    check(32'(n), 32'(e));
  endtask
  task automatic t_hazard;
    logic [31:0] q;
    pair(CL_LOAD, 16'h0051, 6'h08, 2);
    pair(CL_LOAD, 16'h0021, 6'h08, 1);
    pair(CL_STACKGRP, 16'h000f, 6'h04, 2);
    pair(CL_STACKGRP, 16'h0021, 6'h20, 2);
    pair(CL_STACKGRP, 16'h0021, 6'h08, 1);
    pair(CL_MUL, 16'h0040, 6'h02, 2);
    pair(CL_MUL, 16'h0000, 6'h02, 1);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check({16'h0, q[15:0]}, 32'h4);
    wb(1'b1, REG_CTRL, 32'h0, q);
    pair(CL_LOAD, 16'h0051, 6'h08, 1);
    wb(1'b1, REG_CTRL, 32'h1, q);
    $display("interlock test done");
  endtask
  task automatic t_flags;
    logic [31:0] q;
    int n;
    insnFlagOps <= 8'he4;
    aluFlags <= 4'h5;
    issue(CL_PLAIN, 16'h0, 6'h0, IMM_NONE, n);
    idle(1);
    check(32'(flagsOut), 32'h9);
    insnFlagOps <= 8'h72;
    aluFlags <= 4'h2;
    issue(CL_PLAIN, 16'h0, 6'h0, IMM_NONE, n);
    idle(1);
    check(32'(flagsOut), 32'he);
    insnFlagOps <= 8'h55;
    wb(1'b0, REG_FLAGS, 32'h0, q);
    check(q, 32'he);
    $display("flag test done");
  endtask
  task automatic t_mem(input logic [3:0] d, input odi_amode_t m,
                       input logic [31:0] s);
    int n;
    memWait <= d;
    insnAddrMode <= m;
    issue(CL_PLAIN, 16'h0003, 6'h01, IMM_NONE, n);
    insnValid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (memDone !== 1'b1 && n < 40);
    check(32'(n), 32'(d) + 32'h5);
    check({31'h0, regStepEn}, 32'h1);
    check(regStepVal, s);
    check(addrOffset, (m == AM_PUSH) ? STEP_WORD_NEG : 32'h0);
    check(32'(addrRegIdx), (m == AM_POSTINC) ? 32'h3 : 32'hf);
    check(32'(regStepIdx), (m == AM_POSTINC) ? 32'h3 : 32'hf);
    insnAddrMode <= AM_NONE;
    idle(4);
    $display("memory test done");
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {wb_we_i, wb_stb_i, wb_cyc_i, insnValid} = 4'h0;
    {insnFormatA, insnReadsDest, insnReadsSource} = 3'h0;
    {insnWritesDest, insnUsesDedicated, insnUsesMem} = 3'h0;
    wb_sel_i = 4'hf;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    insnWord = 16'h0;
    insnClass = CL_PLAIN;
    insnImmKind = IMM_NONE;
    insnAddrMode = AM_NONE;
    insnFlagOps = 8'h55;
    aluFlags = 4'h0;
    memWait = 4'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_decode;
    t_hazard;
    t_flags;
    t_mem(4'h0, AM_PUSH, STEP_WORD_NEG);
    t_mem(4'h6, AM_POSTINC, STEP_WORD);
    t_mem(4'h2, AM_POP, STEP_WORD);
    close_out;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    $display("watchdog expired");
    close_out;
  end
endmodule
